// ---- logic/alds_pkg.sv ----
// How it works
// - mode pin: 1 sequential, 0 random entry
// - after clear, first entry lands at location 0
// - later entries go to next higher location
// - shared pin drives full high after 8 entries
// - full may feed next device's cascade enable
// - sequential low clear: counter, memory, display cleared
// - random address: pin0 lsb, pin2 msb
// - sequential: cascade enable high accepts, low ignores
// - write strobe active low, qualified by chip select
// - six active-high bits carry the character code
// - eight 6-bit entries, 64-glyph font
// - sixteen segments plus point, one output each
// - scan runs continuously unless a write is active
// - all digits off between character positions
// - oscillator pin held low: shutdown, memory kept
// - host may supply the oscillator clock
// - mode, address, enable latched at strobe start
// - data taken at strobe end, then stored
// - sequential write needs enable high, full low
// - clear: location 000, entries 100000
package alds_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
    localparam int CHARS         = 8;
    localparam int CODE_W        = 6;
    localparam int SEG_W         = 16;

    localparam logic [5:0] BLANK_CODE = 6'h20;
    localparam logic [2:0] LOC_FIRST  = 3'h0;
    localparam logic [2:0] LOC_LAST   = 3'h7;

    // scan timing
    localparam int         PRESCALE_DIV = 64;
    localparam int         BLANK_TICKS  = 1;
    localparam logic [5:0] BLANK_FROM   = 6'(PRESCALE_DIV - BLANK_TICKS);
    localparam logic [5:0] PRESCALE_END = 6'(PRESCALE_DIV - 1);

    // oscillator held low longer than this means shutdown
    localparam int OFF_LOW_NS  = 50000;
    localparam int OFF_LOW_CYC = (OFF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // host pin timing (least times, rounded up)
    localparam int         ADDR_SETUP_NS  = 100;
    localparam int         WR_LOW_NS      = 500;
    localparam int         ADDR_HOLD_NS   = 125;
    localparam int         WR_HIGH_NS     = 760;
    localparam logic [7:0] ADDR_SETUP_CYC = 8'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WR_LOW_CYC     = 8'((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ADDR_HOLD_CYC  = 8'((ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WR_HIGH_CYC    = 8'((WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // host-made oscillator
    localparam int         OSC_HZ       = 200000;
    localparam logic [7:0] OSC_HALF_CYC = 8'(CLK_HZ / (2 * OSC_HZ));

    // host registers
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  CMD_OFS        = 8'h04;
    localparam logic [7:0]  CLEAR_OFS      = 8'h08;
    localparam logic [7:0]  STATUS_OFS     = 8'h0c;
    localparam int          CTRL_MODE_BIT  = 0;
    localparam int          CTRL_RUN_BIT   = 1;
    localparam int          CTRL_CASC_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET     = 3'h2;
    localparam int          CMD_ADDR_LSB   = 8;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_FULL_BIT  = 1;

    typedef struct packed {
        logic       write_strobe_n;
        logic       chip_select;
        logic       access_mode;
        logic       addr0;
        logic       addr1;
        logic       addr2;
        logic       osc;
        logic [5:0] code;
    } alds_pins_type;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_LOW,
        PH_HOLD,
        PH_RECOVER
    } alds_phase_type;
endpackage

// ---- logic/alds_if.sv ----
`timescale 1ns/1ps
interface alds_if;
    logic [5:0] char_code_in;
    logic       write_strobe_n;
    logic       chip_select;
    logic       access_mode;
    logic       addr0_or_cascade_pin;
    logic       addr1_or_clear_pin;
    logic       osc_shutdown_pin;
    logic       host_addr2_out;
    logic       host_addr2_oe_n;
    logic       entries_full_out;
    logic       entries_full_oe_n;
    logic       addr2_or_full_pin;

    // device drive wins; an undriven wire reads low
    assign addr2_or_full_pin = !entries_full_oe_n ? entries_full_out :
                               (!host_addr2_oe_n ? host_addr2_out : 1'b0);

    modport device (
        input  char_code_in,
        input  write_strobe_n,
        input  chip_select,
        input  access_mode,
        input  addr0_or_cascade_pin,
        input  addr1_or_clear_pin,
        input  osc_shutdown_pin,
        input  addr2_or_full_pin,
        output entries_full_out,
        output entries_full_oe_n
    );

    modport host (
        output char_code_in,
        output write_strobe_n,
        output chip_select,
        output access_mode,
        output addr0_or_cascade_pin,
        output addr1_or_clear_pin,
        output osc_shutdown_pin,
        output host_addr2_out,
        output host_addr2_oe_n,
        input  addr2_or_full_pin
    );
endinterface

// ---- logic/alds_font.sv ----
`timescale 1ns/1ps
module alds_font (
    input  wire logic [5:0]  code,
    output logic      [16:0] glyph
);
    // bit 16 is the point, bits 15..0 the segments; index is the 6-bit code
    localparam logic [0:63][16:0] FONT = {
        17'h0_b3f8, 17'h0_0cff, 17'h0_c3f3, 17'h0_003f, 17'h0_c3fc, 17'h0_00fb, 17'h0_00c3, 17'h0_00bf,
        17'h0_00cc, 17'h0_cc33, 17'h0_007c, 17'h0_2a0c, 17'h0_000f, 17'h0_08cc, 17'h0_22cc, 17'h0_00ff,
        17'h0_01cf, 17'h0_20ff, 17'h0_21cf, 17'h0_01bb, 17'h0_cc03, 17'h0_00fc, 17'h0_440c, 17'h0_60cc,
        17'h0_6a00, 17'h0_c800, 17'h0_4433, 17'h0_cc12, 17'h0_2200, 17'h0_cc21, 17'h0_0005, 17'h0_0030,
        17'h0_0000, 17'h1_0c00, 17'h0_0804, 17'h0_cd3c, 17'h0_cdbb, 17'h0_dd99, 17'h0_a2e3, 17'h0_0800,
        17'h0_2a00, 17'h0_6000, 17'h0_ff00, 17'h0_cc00, 17'h0_4000, 17'h0_0100, 17'h1_0000, 17'h0_4400,
        17'h0_44ff, 17'h0_040c, 17'h0_0177, 17'h0_013f, 17'h0_018c, 17'h0_21b3, 17'h0_01fb, 17'h0_000f,
        17'h0_01ff, 17'h0_01bf, 17'h0_8800, 17'h0_4800, 17'h0_2a00, 17'h0_0130, 17'h0_6100, 17'h1_0907
    };

    assign glyph = FONT[code];
endmodule

// ---- logic/alds_device_end.sv ----
`timescale 1ns/1ps
module alds_device_end #(
    parameter int OFF_LOW_CYCLES = alds_pkg::OFF_LOW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    alds_if.device           link,
    output logic      [15:0] segment_drive_out,
    output logic             decimal_point_out,
    output logic      [7:0]  digit_drive_out
);
    typedef struct packed {
        alds_pkg::alds_pins_type meta;
        alds_pkg::alds_pins_type pins;
        logic                    strobe_prev;
        logic                    osc_prev;
        logic                    seq_mode;
        logic [2:0]              addr;
        logic                    cascade;
        logic [2:0]              loc;
        logic                    full;
        logic [7:0][5:0]         mem;
        logic [5:0]              prescale;
        logic [2:0]              scan;
        logic [15:0]             low_cnt;
        logic                    shutdown;
        logic [15:0]             seg;
        logic                    point;
        logic [7:0]              digit;
    } alds_dev_state_type;

    localparam alds_dev_state_type DEV_RESET = '{
        mem:     {8{alds_pkg::BLANK_CODE}},
        loc:     alds_pkg::LOC_FIRST,
        default: '0
    };

    alds_dev_state_type r_reg;
    alds_dev_state_type r_next;
    logic [16:0]        glyph;
    logic               strobe;
    logic               seq_ok;
    logic               active;
    logic               clearing;
    logic               osc_rise;
    logic               blank;
    logic               drive;

    alds_font i_alds_font (
        .code  (r_reg.mem[r_reg.scan]),
        .glyph (glyph)
    );

    always_comb begin
        r_next = r_reg;
        // two-flop synchroniser on every pin
        r_next.meta = '{
            write_strobe_n: link.write_strobe_n,
            chip_select:    link.chip_select,
            access_mode:    link.access_mode,
            addr0:          link.addr0_or_cascade_pin,
            addr1:          link.addr1_or_clear_pin,
            addr2:          link.addr2_or_full_pin,
            osc:            link.osc_shutdown_pin,
            code:           link.char_code_in
        };
        r_next.pins = r_reg.meta;

        strobe = ~r_reg.pins.write_strobe_n & r_reg.pins.chip_select;
        r_next.strobe_prev = strobe;

        // strobe start: latch mode, address and cascade enable
        if (strobe && !r_reg.strobe_prev) begin
            r_next.seq_mode = r_reg.pins.access_mode;
            r_next.addr     = {r_reg.pins.addr2, r_reg.pins.addr1, r_reg.pins.addr0};
            r_next.cascade  = r_reg.pins.addr0;
        end

        seq_ok = r_reg.seq_mode & r_reg.cascade & ~r_reg.full;
        active = strobe & (~r_reg.seq_mode | seq_ok);

        // strobe end: take the code and store it
        if (!strobe && r_reg.strobe_prev) begin
            if (!r_reg.seq_mode) begin
                r_next.mem[r_reg.addr] = r_reg.pins.code;
            end else if (seq_ok) begin
                r_next.mem[r_reg.loc] = r_reg.pins.code;
                r_next.loc            = r_reg.loc + 3'h1;
                if (r_reg.loc == alds_pkg::LOC_LAST) begin
                    r_next.full = 1'b1;
                end
            end
        end

        // clear is level driven and ignores the strobe
        clearing = r_reg.seq_mode & ~r_reg.pins.addr1;
        if (clearing) begin
            r_next.loc  = alds_pkg::LOC_FIRST;
            r_next.full = 1'b0;
            r_next.mem  = {8{alds_pkg::BLANK_CODE}};
        end

        // oscillator edge and shutdown detection
        osc_rise = r_reg.pins.osc & ~r_reg.osc_prev;
        r_next.osc_prev = r_reg.pins.osc;
        if (r_reg.pins.osc) begin
            r_next.low_cnt = '0;
        end else if (r_reg.low_cnt != 16'(OFF_LOW_CYCLES)) begin
            r_next.low_cnt = r_reg.low_cnt + 16'h0001;
        end
        r_next.shutdown = (r_reg.low_cnt == 16'(OFF_LOW_CYCLES));

        // scan timing; frozen while a write is active
        if (r_reg.shutdown) begin
            r_next.prescale = '0;
            r_next.scan     = '0;
        end else if (osc_rise && !active) begin
            r_next.prescale = r_reg.prescale + 6'h01;
            if (r_reg.prescale == alds_pkg::PRESCALE_END) begin
                r_next.scan = r_reg.scan + 3'h1;
            end
        end

        // blanking sits at the tail of each position so it always precedes a change
        blank = (r_reg.prescale >= alds_pkg::BLANK_FROM);
        drive = ~r_reg.shutdown & ~active & ~clearing & ~blank;

        r_next.digit = drive ? (8'h01 << r_reg.scan) : 8'h00;
        r_next.seg   = drive ? glyph[15:0] : 16'h0000;
        r_next.point = drive ? glyph[16] : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= DEV_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign segment_drive_out      = r_reg.seg;
    assign decimal_point_out      = r_reg.point;
    assign digit_drive_out        = r_reg.digit;
    // full pin is an output only in sequential mode and released in shutdown
    assign link.entries_full_out  = r_reg.full;
    assign link.entries_full_oe_n = ~(r_reg.seq_mode & ~r_reg.shutdown);
endmodule

// ---- logic/alds_host_end.sv ----
`timescale 1ns/1ps
module alds_host_end (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    alds_if.host             link
);
    typedef struct packed {
        logic [2:0]               ctrl;
        logic [5:0]               code;
        logic [2:0]               addr;
        alds_pkg::alds_phase_type phase;
        logic [7:0]               cnt;
        logic                     is_clear;
        logic                     applied_seq;
        logic [7:0]               osc_cnt;
        logic                     osc;
        logic                     full_meta;
        logic                     full_sync;
        logic [31:0]              rdata;
        logic                     slverr;
        logic                     pin_wr_n;
        logic                     pin_cs;
        logic                     pin_a0;
        logic                     pin_a1;
        logic                     pin_a2;
        logic                     pin_a2_oe_n;
    } alds_host_state_type;

    localparam alds_host_state_type HOST_RESET = '{
        ctrl:        alds_pkg::CTRL_RESET,
        phase:       alds_pkg::PH_IDLE,
        pin_wr_n:    1'b1,
        pin_a1:      1'b1,
        pin_a2_oe_n: 1'b1,
        default:     '0
    };

    alds_host_state_type r_reg;
    alds_host_state_type r_next;
    logic                busy;
    logic                seq;
    logic                cmd_hit;
    logic                strobing;

    assign busy    = (r_reg.phase != alds_pkg::PH_IDLE);
    assign seq     = r_reg.ctrl[alds_pkg::CTRL_MODE_BIT];
    assign cmd_hit = (paddr == alds_pkg::CMD_OFS) || (paddr == alds_pkg::CLEAR_OFS);
    // back-pressure: a new pin cycle waits until the last one ends
    assign pready  = ~(psel & penable & pwrite & cmd_hit & busy);

    always_comb begin
        r_next = r_reg;
        r_next.full_meta = link.addr2_or_full_pin;
        r_next.full_sync = r_reg.full_meta;

        // read data and error are fixed in the setup cycle
        if (psel && !penable) begin
            r_next.slverr = 1'b0;
            r_next.rdata  = 32'h0000_0000;
            unique case (paddr)
                alds_pkg::CTRL_OFS:   r_next.rdata = {29'h0, r_reg.ctrl};
                alds_pkg::CMD_OFS:    r_next.rdata = {21'h0, r_reg.addr, 2'h0, r_reg.code};
                alds_pkg::CLEAR_OFS:  r_next.rdata = 32'h0000_0000;
                alds_pkg::STATUS_OFS: r_next.rdata = {30'h0, r_reg.full_sync, busy};
                default:              r_next.slverr = 1'b1;
            endcase
        end

        if (psel && penable && pready && pwrite) begin
            if (paddr == alds_pkg::CTRL_OFS) begin
                r_next.ctrl = pwdata[2:0];
            end else if (paddr == alds_pkg::CMD_OFS) begin
                r_next.code     = pwdata[5:0];
                r_next.addr     = pwdata[alds_pkg::CMD_ADDR_LSB +: 3];
                r_next.is_clear = 1'b0;
                r_next.phase    = alds_pkg::PH_SETUP;
                r_next.cnt      = alds_pkg::ADDR_SETUP_CYC - 8'h01;
            end else if (paddr == alds_pkg::CLEAR_OFS && seq) begin
                r_next.is_clear = 1'b1;
                r_next.phase    = alds_pkg::PH_LOW;
                r_next.cnt      = alds_pkg::WR_LOW_CYC - 8'h01;
            end
        end else if (busy) begin
            if (r_reg.cnt != 8'h00) begin
                r_next.cnt = r_reg.cnt - 8'h01;
            end else begin
                unique case (r_reg.phase)
                    alds_pkg::PH_SETUP: begin
                        r_next.phase = alds_pkg::PH_LOW;
                        r_next.cnt   = alds_pkg::WR_LOW_CYC - 8'h01;
                    end
                    alds_pkg::PH_LOW: begin
                        r_next.phase = r_reg.is_clear ? alds_pkg::PH_RECOVER : alds_pkg::PH_HOLD;
                        r_next.cnt   = r_reg.is_clear ? alds_pkg::WR_HIGH_CYC - 8'h01
                                                      : alds_pkg::ADDR_HOLD_CYC - 8'h01;
                        // device latches the new mode a few cycles into the strobe; drive only after that
                        if (!r_reg.is_clear) begin
                            r_next.applied_seq = seq;
                        end
                    end
                    alds_pkg::PH_HOLD: begin
                        r_next.phase = alds_pkg::PH_RECOVER;
                        r_next.cnt   = alds_pkg::WR_HIGH_CYC - 8'h01;
                    end
                    alds_pkg::PH_RECOVER: r_next.phase = alds_pkg::PH_IDLE;
                    alds_pkg::PH_IDLE:    r_next.phase = alds_pkg::PH_IDLE;
                endcase
            end
        end

        // oscillator made here; holding it low shuts the device down
        if (!r_reg.ctrl[alds_pkg::CTRL_RUN_BIT]) begin
            r_next.osc     = 1'b0;
            r_next.osc_cnt = 8'h00;
        end else if (r_reg.osc_cnt == alds_pkg::OSC_HALF_CYC - 8'h01) begin
            r_next.osc     = ~r_reg.osc;
            r_next.osc_cnt = 8'h00;
        end else begin
            r_next.osc_cnt = r_reg.osc_cnt + 8'h01;
        end

        strobing = (r_next.phase == alds_pkg::PH_LOW) && !r_next.is_clear;
        r_next.pin_cs = !r_next.is_clear && (r_next.phase == alds_pkg::PH_SETUP ||
                        r_next.phase == alds_pkg::PH_LOW || r_next.phase == alds_pkg::PH_HOLD);
        r_next.pin_wr_n = ~strobing;
        r_next.pin_a0   = seq ? r_reg.ctrl[alds_pkg::CTRL_CASC_BIT] : r_next.addr[0];
        r_next.pin_a1   = seq ? ~((r_next.phase == alds_pkg::PH_LOW) && r_next.is_clear) : r_next.addr[1];
        r_next.pin_a2   = r_next.addr[2];
        // after a sequential-mode strobe the device owns this pin until a random-mode strobe has been seen
        r_next.pin_a2_oe_n = seq | r_next.applied_seq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= HOST_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata                    = r_reg.rdata;
    assign pslverr                   = r_reg.slverr;
    assign link.char_code_in         = r_reg.code;
    assign link.write_strobe_n       = r_reg.pin_wr_n;
    assign link.chip_select          = r_reg.pin_cs;
    assign link.access_mode          = seq;
    assign link.addr0_or_cascade_pin = r_reg.pin_a0;
    assign link.addr1_or_clear_pin   = r_reg.pin_a1;
    assign link.osc_shutdown_pin     = r_reg.osc;
    assign link.host_addr2_out       = r_reg.pin_a2;
    assign link.host_addr2_oe_n      = r_reg.pin_a2_oe_n;
endmodule

// ---- bench/alds_checker.sv ----
`timescale 1ns/1ps
module alds_checker #(
    parameter int OFF_LOW_CYCLES = alds_pkg::OFF_LOW_CYC
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [5:0] char_code_in,
    input wire logic       write_strobe_n,
    input wire logic       chip_select,
    input wire logic       access_mode,
    input wire logic       addr0_or_cascade_pin,
    input wire logic       addr1_or_clear_pin,
    input wire logic       osc_shutdown_pin,
    input wire logic       host_addr2_oe_n,
    input wire logic       entries_full_oe_n
);
    localparam int OSC_HI_MAX = int'(alds_pkg::OSC_HALF_CYC);
    logic [15:0] osc_hi_reg;
    logic [15:0] osc_lo_reg;

    // run lengths of the oscillator line; low count saturates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_hi_reg <= 16'h0000;
            osc_lo_reg <= 16'h0000;
        end else begin
            osc_hi_reg <= osc_shutdown_pin ? osc_hi_reg + 16'h0001 : 16'h0000;
            osc_lo_reg <= osc_shutdown_pin ? 16'h0000 : (&osc_lo_reg ? osc_lo_reg : osc_lo_reg + 16'h0001);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_setup;
        (chip_select && write_strobe_n) [*2];
    endsequence
    sequence seq_low;
        (chip_select && !write_strobe_n) [*8] ##1 (chip_select && !write_strobe_n) [*2];
    endsequence
    sequence seq_hold;
        (chip_select && write_strobe_n) [*3] ##1 !chip_select;
    endsequence

    a_write_frame: assert property ($rose(chip_select) |-> seq_setup ##1 seq_low ##1 seq_hold)
        else $error("pin write frame out of shape");
    a_strobe_qualified: assert property (!write_strobe_n |-> chip_select)
        else $error("strobe low without chip select");
    a_low_width: assert property ($fell(write_strobe_n) |-> seq_low)
        else $error("strobe low time wrong");
    a_hold_after: assert property ($rose(write_strobe_n) |-> seq_hold)
        else $error("hold after strobe wrong");
    a_qual_stable: assert property (!write_strobe_n |-> $stable(char_code_in) && $stable(access_mode)
        && $stable(addr0_or_cascade_pin) && $stable(addr1_or_clear_pin))
        else $error("qualifiers moved during strobe");
    a_no_contention: assert property (!entries_full_oe_n |-> host_addr2_oe_n)
        else $error("shared pin driven by both ends");
    a_full_shutdown: assert property (int'(osc_lo_reg) > OFF_LOW_CYCLES + 5 |-> entries_full_oe_n)
        else $error("full pin driven in shutdown");
    a_osc_half: assert property (int'(osc_hi_reg) <= OSC_HI_MAX)
        else $error("oscillator high too long");
endmodule

// ---- bench/tb_alnum_led_display_scan_driver.sv ----
`timescale 1ns/1ps
module tb_alnum_led_display_scan_driver;
    localparam int OFF_CYC = 200;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        note;
    logic [15:0] segment_drive_out;
    logic        decimal_point_out;
    logic [7:0]  digit_drive_out;
    logic [7:0]  dp_exp;
    logic [31:0] rd;
    logic [32:0] exp_q[$];
    int          mismatches;
    int          tests_run;
    int          k;

    alds_if link ();
    alds_host_end i_alds_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    alds_device_end #(.OFF_LOW_CYCLES(OFF_CYC)) i_alds_device_end (.pclk(pclk), .presetn(presetn),
        .link(link), .segment_drive_out(segment_drive_out), .decimal_point_out(decimal_point_out),
        .digit_drive_out(digit_drive_out));
    alds_checker #(.OFF_LOW_CYCLES(OFF_CYC)) i_alds_checker (.pclk(pclk), .presetn(presetn),
        .char_code_in(link.char_code_in), .write_strobe_n(link.write_strobe_n),
        .chip_select(link.chip_select), .access_mode(link.access_mode),
        .addr0_or_cascade_pin(link.addr0_or_cascade_pin), .addr1_or_clear_pin(link.addr1_or_clear_pin),
        .osc_shutdown_pin(link.osc_shutdown_pin), .host_addr2_oe_n(link.host_addr2_oe_n),
        .entries_full_oe_n(link.entries_full_oe_n));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] expv);
        tests_run++;
        if (seen !== expv) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic close_out;
        $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic nt,
                       input logic [32:0] e);
        @(posedge pclk);
        if (nt) exp_q.push_back(e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        note    <= nt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        note    <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0000_0000, 1'b1, e);
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 100; i++) begin
            apb(1'b0, alds_pkg::STATUS_OFS, 32'h0000_0000, 1'b0, 33'h0_0000_0000);
            if (rd[alds_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
    endtask

    // mode bits must not move under a pin write in flight
    task automatic ctrl(input logic [31:0] v);
        wait_idle();
        apb(1'b1, alds_pkg::CTRL_OFS, v, 1'b0, 33'h0_0000_0000);
    endtask

    task automatic cmd(input logic [2:0] a, input logic b);
        apb(1'b1, alds_pkg::CMD_OFS, {21'h00_0000, a, 2'b00, b ? 6'h2e : 6'h20}, 1'b0, 33'h0_0000_0000);
    endtask

    task automatic watch(input int n);
        int i;
        int j;
        logic [7:0] prev;
        for (i = 0; i < 8000 && digit_drive_out !== 8'h01; i++) @(posedge pclk);
        for (j = 0; j < n; j++) begin
            if (j > 0) begin
                prev = digit_drive_out;
                for (i = 0; i < 8000 && digit_drive_out === prev; i++) @(posedge pclk);
                check("blank gap", {25'h000_0000, digit_drive_out}, 33'h0_0000_0000);
                for (i = 0; i < 8000 && digit_drive_out === 8'h00; i++) @(posedge pclk);
            end
            check("digit", {25'h000_0000, digit_drive_out}, 33'(8'h01 << j));
            check("point", {32'h0000_0000, decimal_point_out}, {32'h0000_0000, dp_exp[j]});
            check("segments", {17'h0_0000, segment_drive_out}, 33'h0_0000_0000);
        end
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && note && exp_q.size() > 0) begin
            check("apb read", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        close_out();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        note = 1'b0;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(32'hc17b_d39f));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdx(alds_pkg::CTRL_OFS, {30'h0000_0000, alds_pkg::CTRL_RESET});
        rdx(alds_pkg::STATUS_OFS, 33'h0_0000_0000);
        rdx(8'h10, 33'h1_0000_0000);
        $display("test reset done");
        ctrl(32'h0000_0003);
        dp_exp = 8'($urandom());
        // a first strobe latches sequential mode so the clear pin is honoured
        cmd(3'h2, 1'b1);
        wait_idle();
        apb(1'b1, alds_pkg::CLEAR_OFS, 32'h0000_0000, 1'b0, 33'h0_0000_0000);
        cmd(3'h2, !dp_exp[0]);
        ctrl(32'h0000_0007);
        for (k = 0; k < 8; k++) cmd(3'h2, dp_exp[k]);
        wait_idle();
        rdx(alds_pkg::STATUS_OFS, 33'h0_0000_0002);
        cmd(3'h2, !dp_exp[0]);
        $display("test sequential done");
        ctrl(32'h0000_0002);
        // first random write after sequential sees the device's full level on the msb
        cmd(3'h7, dp_exp[7]);
        cmd(3'h6, !dp_exp[6]);
        dp_exp[6] = !dp_exp[6];
        cmd(3'h1, !dp_exp[1]);
        dp_exp[1] = !dp_exp[1];
        ctrl(32'h0000_0000);
        repeat (OFF_CYC + 20) @(posedge pclk);
        check("shutdown", {24'h00_0000, digit_drive_out, decimal_point_out}, 33'h0_0000_0000);
        ctrl(32'h0000_0002);
        watch(8);
        $display("test random and scan done");
        ctrl(32'h0000_0007);
        cmd(3'h2, 1'b1);
        wait_idle();
        rdx(alds_pkg::STATUS_OFS, 33'h0_0000_0002);
        apb(1'b1, alds_pkg::CLEAR_OFS, 32'h0000_0000, 1'b0, 33'h0_0000_0000);
        wait_idle();
        rdx(alds_pkg::STATUS_OFS, 33'h0_0000_0000);
        cmd(3'h2, 1'b1);
        dp_exp = 8'h01;
        ctrl(32'h0000_0001);
        repeat (OFF_CYC + 20) @(posedge pclk);
        ctrl(32'h0000_0007);
        watch(2);
        $display("test clear done");
        close_out();
    end
endmodule
